// *** core/sdc_defs.svh ***
/*
  sdc_defs.svh: register offsets, field positions, reset values and
  timing counts of the shutdown control block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

// byte addresses on the apb bus
`define SDC_OFF_STOP_CTRL    12'h000
`define SDC_OFF_SHDN_EN      12'h004
`define SDC_OFF_INT_WAKE     12'h008
`define SDC_OFF_WDOG_EN      12'h00C
`define SDC_OFF_WDOG         12'h010
`define SDC_OFF_CLK_SUP      12'h014
`define SDC_OFF_CLK_SRC      12'h018
`define SDC_OFF_LV_DET       12'h01C
`define SDC_OFF_REG_SEL      12'h020
`define SDC_OFF_STATUS       12'h024

// stop control fields
`define SDC_STOP_REQ_BIT     7
`define SDC_MAIN_DIS_BIT     6
`define SDC_SUB_DIS_BIT      5
`define SDC_HIZ_BIT          4
`define SDC_SETTLE_LSB       2
// shutdown enable field
`define SDC_SHDN_EN_BIT      7
// internal wake fields
`define SDC_WD_FLAG_BIT      3
`define SDC_WD_MIRROR_BIT    2
`define SDC_RTC_FLAG_BIT     1
`define SDC_RTC_EN_BIT       0
// watchdog enable / watchdog fields
`define SDC_RUN_STOP_BIT     4
`define SDC_WD_CLEAR_BIT     3
// clock supervisor fields
`define SDC_RC_STOP_BIT      4
`define SDC_MAIN_SUP_BIT     3
`define SDC_SUB_SUP_BIT      2
// low voltage fields
`define SDC_LV_EXT_BIT       1
`define SDC_LV_INT_BIT       0

// reset values
`define SDC_RST_SETTLE       2'h0
`define SDC_RST_CLK_SUP      8'h1C
`define SDC_RST_RTC_SEL      2'h0
`define SDC_RST_SUB_LEVEL    8'h01
`define SDC_SUB_LEVEL_LOW    8'h00

// rtc source encodings
`define SDC_RTC_SEL_SUB      2'h1
`define SDC_RTC_SEL_RC       2'h2

// reset pulse count toward the processor, in ns, and in cycles of 4 ns; the init pulse lasts one cycle longer (11 cycles)
`define SDC_INIT_PULSE_NS    40
`define SDC_CLK_NS           4
`define SDC_INIT_CYC         (`SDC_INIT_PULSE_NS / `SDC_CLK_NS)

`endif

// *** core/sdc_pkg.sv ***
/*
  sdc_pkg.sv: types of the shutdown control block.
  Assumes sdc_defs.svh is compiled alongside.
*/
package sdc_pkg;

  typedef enum logic [1:0] {SDC_RUN, SDC_STOP, SDC_SHDN, SDC_INIT} sdc_state_t;

  // clock choices driven to the clock tree
  typedef struct packed {
    logic       main_osc_on;
    logic       sub_osc_on;
    logic       rc_osc_on;
    logic       sub_from_rc_div2;
    logic [1:0] rtc_clock_select;
    logic       cpu_on_rc;
  } sdc_clk_t;

  // raw events from the oscillators, watchdog and rtc
  typedef struct packed {
    logic wdog_timeout;
    logic main_osc_fail;
    logic sub_osc_fail;
    logic rtc_irq;
  } sdc_evt_t;

endpackage : sdc_pkg

// *** core/sdc_sync.sv ***
/*
  sdc_sync.sv: three-flop synchroniser; a change is taken once the second
  and third stage agree.
  Assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module sdc_sync
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sdc_sync_st_t;

  sdc_sync_st_t st;
  sdc_sync_st_t next_st;

  always_comb
  begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3)
    begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule : sdc_sync

// *** core/sdc_apb_if.sv ***
/*
  sdc_apb_if.sv: apb slave front end; takes rd_hit from the decode in sdc_top (one word per register) and
  answers every access without wait states, pslverr on unmapped offsets.
  Assumes a standard apb master on pclk.
*/
`timescale 1ns/10ps
module sdc_apb_if
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] rd_word,
  input  wire logic        rd_hit,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       wr_byte
);
  typedef struct packed {
    logic [31:0] rdata;
  } sdc_apb_st_t;

  sdc_apb_st_t st;
  sdc_apb_st_t next_st;
  logic        access;

  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = access & ~rd_hit;
  assign wr_stb  = access & pwrite & rd_hit;
  assign rd_stb  = access & ~pwrite & rd_hit;
  assign wr_byte = pwdata[7:0];

  // data registered in setup so the access phase sees stable read data
  always_comb
  begin
    next_st = st;
    if (psel && !penable && !pwrite)
    begin
      next_st.rdata = rd_hit ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
endmodule : sdc_apb_if

// *** core/sdc_top.sv ***
/*
  sdc_top.sv: shutdown control with stop/shutdown sequencing, wake sources,
  clock supervision and the registers that survive recovery.
  Assumes event inputs come from other clock domains or pins; pclk stays
  alive across recovery (models the always-on domain).
*/
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "sdc_defs.svh"

module sdc_top
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic [31:0]          prdata,
  input  wire sdc_pkg::sdc_evt_t evt_in,
  input  wire logic            ext_wake,
  input  wire logic            wake_irq,
  output logic                 init_reset_n,
  output logic                 in_stop,
  output logic                 in_shutdown,
  output logic                 pulls_disabled,
  output logic                 pins_hiz,
  output logic                 sub_reg_low,
  output logic                 wdog_clear,
  output sdc_pkg::sdc_clk_t    clk_ctrl
);
  typedef struct packed {
    sdc_pkg::sdc_state_t state;
    logic       main_osc_disable;
    logic       sub_osc_disable;
    logic       pin_float_in_stop;
    logic [1:0] osc_settle_time;
    logic       shutdown_enable_bit;
    logic       watchdog_run_in_stop;
    logic       watchdog_wake_flag;
    logic       rtc_wake_flag;
    logic       rtc_wake_enable;
    logic       rc_osc_stop_enable;
    logic       main_supervise_enable;
    logic       sub_supervise_enable;
    logic       sub_failed;
    logic [1:0] rtc_clock_select;
    logic       lv_external_powerdown;
    logic       lv_internal_powerdown;
    logic [7:0] sub_regulator_level;
    logic       cpu_on_rc;
    logic       wdog_clear;
    logic [3:0] init_cnt;
  } sdc_st_t;

  sdc_st_t st;
  sdc_st_t next_st;

  logic        wdog_to;
  logic        main_fail;
  logic        sub_fail;
  logic        rtc_ev;
  logic        wr_stb;
  logic [7:0]  wr_byte;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        init_evt;
  logic        rc_running;
  logic        main_sup_on;
  logic        stopped;

  sdc_sync u_sync_wd   (.pclk(pclk), .presetn(presetn), .din(evt_in.wdog_timeout),
                        .dout(wdog_to));
  sdc_sync u_sync_main (.pclk(pclk), .presetn(presetn), .din(evt_in.main_osc_fail),
                        .dout(main_fail));
  sdc_sync u_sync_sub  (.pclk(pclk), .presetn(presetn), .din(evt_in.sub_osc_fail),
                        .dout(sub_fail));
  sdc_sync u_sync_rtc  (.pclk(pclk), .presetn(presetn), .din(evt_in.rtc_irq),
                        .dout(rtc_ev));

  sdc_apb_if u_apb
  (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .rd_word (rd_word),
    .rd_hit  (rd_hit),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .wr_stb  (wr_stb),
    .rd_stb  (),
    .wr_byte (wr_byte)
  );

  assign stopped    = (st.state == sdc_pkg::SDC_STOP) || (st.state == sdc_pkg::SDC_SHDN);
  // rc forced on by run-in-stop
  assign rc_running = !stopped || st.rc_osc_stop_enable || st.watchdog_run_in_stop;
  assign main_sup_on = st.main_supervise_enable && !(stopped && st.main_osc_disable)
                       && rc_running;

  // supervisor reset rides the watchdog line; in shutdown only while it runs
  always_comb
  begin
    init_evt = wdog_to || (main_fail && main_sup_on);
    if (st.state == sdc_pkg::SDC_SHDN && !st.watchdog_run_in_stop)
    begin
      init_evt = 1'b0;
    end
  end

  // read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      `SDC_OFF_STOP_CTRL:
      begin
        rd_word[`SDC_MAIN_DIS_BIT] = st.main_osc_disable;
        rd_word[`SDC_SUB_DIS_BIT]  = st.sub_osc_disable;
        rd_word[`SDC_HIZ_BIT]      = st.pin_float_in_stop;
        rd_word[`SDC_SETTLE_LSB +: 2] = st.osc_settle_time;
      end
      `SDC_OFF_SHDN_EN:  rd_word[`SDC_SHDN_EN_BIT] = st.shutdown_enable_bit;
      `SDC_OFF_INT_WAKE:
      begin
        rd_word[`SDC_WD_FLAG_BIT]   = st.watchdog_wake_flag;
        rd_word[`SDC_WD_MIRROR_BIT] = st.watchdog_run_in_stop;
        rd_word[`SDC_RTC_FLAG_BIT]  = st.rtc_wake_flag;
        rd_word[`SDC_RTC_EN_BIT]    = st.rtc_wake_enable;
      end
      `SDC_OFF_WDOG_EN:  rd_word[`SDC_RUN_STOP_BIT] = st.watchdog_run_in_stop;
      `SDC_OFF_WDOG:     rd_word[`SDC_WD_CLEAR_BIT] = st.wdog_clear;
      `SDC_OFF_CLK_SUP:
      begin
        rd_word[`SDC_RC_STOP_BIT]  = st.rc_osc_stop_enable;
        rd_word[`SDC_MAIN_SUP_BIT] = st.main_supervise_enable;
        rd_word[`SDC_SUB_SUP_BIT]  = st.sub_supervise_enable;
      end
      `SDC_OFF_CLK_SRC:  rd_word[1:0] = st.rtc_clock_select;
      `SDC_OFF_LV_DET:
      begin
        rd_word[`SDC_LV_EXT_BIT] = st.lv_external_powerdown;
        rd_word[`SDC_LV_INT_BIT] = st.lv_internal_powerdown;
      end
      `SDC_OFF_REG_SEL:  rd_word[7:0] = st.sub_regulator_level;
      `SDC_OFF_STATUS:
      begin
        rd_word[1:0] = st.state;
        rd_word[2]   = st.cpu_on_rc;
        rd_word[3]   = st.sub_failed;
      end
      default:           rd_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    next_st            = st;
    next_st.wdog_clear = 1'b0;
    if (wr_stb)
    begin
      case (paddr)
        `SDC_OFF_STOP_CTRL:
        begin
          next_st.main_osc_disable  = wr_byte[`SDC_MAIN_DIS_BIT];
          next_st.sub_osc_disable   = wr_byte[`SDC_SUB_DIS_BIT];
          next_st.pin_float_in_stop = wr_byte[`SDC_HIZ_BIT];
          next_st.osc_settle_time   = wr_byte[`SDC_SETTLE_LSB +: 2];
          if (wr_byte[`SDC_STOP_REQ_BIT] && st.state == sdc_pkg::SDC_RUN)
          begin
            // enable bit picks the flavour of stop
            next_st.state = st.shutdown_enable_bit ? sdc_pkg::SDC_SHDN
                                                   : sdc_pkg::SDC_STOP;
          end
        end
        `SDC_OFF_SHDN_EN:  next_st.shutdown_enable_bit = wr_byte[`SDC_SHDN_EN_BIT];
        `SDC_OFF_INT_WAKE:
        begin
          next_st.rtc_wake_enable = wr_byte[`SDC_RTC_EN_BIT];
          if (!wr_byte[`SDC_WD_FLAG_BIT])
          begin
            next_st.watchdog_wake_flag = 1'b0;
          end
          if (!wr_byte[`SDC_RTC_FLAG_BIT])
          begin
            next_st.rtc_wake_flag = 1'b0;
          end
        end
        `SDC_OFF_WDOG_EN:
        begin
          // set-only: a zero write leaves it alone
          next_st.watchdog_run_in_stop = st.watchdog_run_in_stop
                                         | wr_byte[`SDC_RUN_STOP_BIT];
        end
        `SDC_OFF_WDOG:     next_st.wdog_clear = ~wr_byte[`SDC_WD_CLEAR_BIT];
        `SDC_OFF_CLK_SUP:
        begin
          next_st.rc_osc_stop_enable    = wr_byte[`SDC_RC_STOP_BIT];
          next_st.main_supervise_enable = wr_byte[`SDC_MAIN_SUP_BIT];
          next_st.sub_supervise_enable  = wr_byte[`SDC_SUB_SUP_BIT];
        end
        `SDC_OFF_CLK_SRC:  next_st.rtc_clock_select = wr_byte[1:0];
        `SDC_OFF_LV_DET:
        begin
          next_st.lv_external_powerdown = wr_byte[`SDC_LV_EXT_BIT];
          next_st.lv_internal_powerdown = wr_byte[`SDC_LV_INT_BIT];
        end
        `SDC_OFF_REG_SEL:  next_st.sub_regulator_level = wr_byte;
        default:           next_st.sub_regulator_level = st.sub_regulator_level;
      endcase
    end

    // sub failure latches substitution, no reset
    if (sub_fail && st.sub_supervise_enable && rc_running
        && !(stopped && st.sub_osc_disable))
    begin
      next_st.sub_failed = 1'b1;
    end

    case (st.state)
      sdc_pkg::SDC_RUN:
      begin
        if (init_evt)
        begin
          next_st.state     = sdc_pkg::SDC_INIT;
          next_st.init_cnt  = 4'(`SDC_INIT_CYC);
          next_st.cpu_on_rc = main_fail && main_sup_on;
        end
      end
      sdc_pkg::SDC_STOP:
      begin
        if (init_evt)
        begin
          next_st.state     = sdc_pkg::SDC_INIT;
          next_st.init_cnt  = 4'(`SDC_INIT_CYC);
          next_st.cpu_on_rc = main_fail && main_sup_on;
        end
        else if (wake_irq)
        begin
          next_st.state = sdc_pkg::SDC_RUN;
        end
      end
      sdc_pkg::SDC_SHDN:
      begin
        if (init_evt || (rtc_ev && st.rtc_wake_enable) || ext_wake)
        begin
          next_st.state    = sdc_pkg::SDC_INIT;
          next_st.init_cnt = 4'(`SDC_INIT_CYC);
          // flag only when the watchdog was allowed to run in stop
          if (wdog_to && st.watchdog_run_in_stop)
          begin
            next_st.watchdog_wake_flag = 1'b1;
          end
          if (rtc_ev && st.rtc_wake_enable)
          begin
            next_st.rtc_wake_flag   = 1'b1;
            next_st.rtc_wake_enable = 1'b0;
          end
          // watchdog recovery on main, supervisor failure on rc
          next_st.cpu_on_rc = main_fail && main_sup_on && !wdog_to;
          // settle time, rtc select, supervisor and flags survive
          next_st.main_osc_disable    = 1'b0;
          next_st.sub_osc_disable     = 1'b0;
          next_st.pin_float_in_stop   = 1'b0;
          next_st.shutdown_enable_bit = 1'b0;
        end
      end
      sdc_pkg::SDC_INIT:
      begin
        if (st.init_cnt == 4'h0)
        begin
          next_st.state = sdc_pkg::SDC_RUN;
        end
        else
        begin
          next_st.init_cnt = st.init_cnt - 4'h1;
        end
      end
      default: next_st.state = sdc_pkg::SDC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st                       <= '0;
      st.state                 <= sdc_pkg::SDC_RUN;
      st.osc_settle_time       <= `SDC_RST_SETTLE;
      st.rc_osc_stop_enable    <= 1'(`SDC_RST_CLK_SUP >> `SDC_RC_STOP_BIT);
      st.main_supervise_enable <= 1'b1;
      st.sub_supervise_enable  <= 1'b1;
      st.rtc_clock_select      <= `SDC_RST_RTC_SEL;
      st.sub_regulator_level   <= `SDC_RST_SUB_LEVEL;
    end
    else
    begin
      st <= next_st;
    end
  end

  // drives low during recovery init and on any watchdog/supervisor init
  assign init_reset_n   = (st.state != sdc_pkg::SDC_INIT);
  assign in_stop        = stopped;
  assign in_shutdown    = (st.state == sdc_pkg::SDC_SHDN);
  assign pulls_disabled = stopped && st.pin_float_in_stop;
  assign pins_hiz       = stopped && st.pin_float_in_stop;
  assign sub_reg_low    = stopped && (st.sub_regulator_level == `SDC_SUB_LEVEL_LOW);
  assign wdog_clear     = st.wdog_clear;

  always_comb
  begin
    clk_ctrl.main_osc_on      = !(stopped && st.main_osc_disable);
    clk_ctrl.sub_osc_on       = !(stopped && st.sub_osc_disable);
    clk_ctrl.rc_osc_on        = rc_running;
    clk_ctrl.sub_from_rc_div2 = st.sub_failed;
    clk_ctrl.rtc_clock_select = st.rtc_clock_select;
    clk_ctrl.cpu_on_rc        = st.cpu_on_rc;
  end
endmodule : sdc_top

// *** test/sdc_top_properties.sv ***
/*
  sdc_top_properties.sv: port-level checker for sdc_top, bound below.
  Assumes one clock pclk and async active-low presetn.
*/
`timescale 1ns/10ps
module sdc_top_properties
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire sdc_pkg::sdc_evt_t evt_in,
  input wire logic              ext_wake,
  input wire logic              init_reset_n,
  input wire logic              in_stop,
  input wire logic              in_shutdown,
  input wire logic              pulls_disabled,
  input wire logic              pins_hiz,
  input wire logic              wdog_clear,
  input wire sdc_pkg::sdc_clk_t clk_ctrl
);
  logic       wr;
  logic [4:0] lo_cnt;
  logic       en_q;
  logic       en_ok;
  logic       run_q;
  assign wr = psel & penable & pwrite;
  // en_ok and run_q forget on any init, so they never claim too much
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_cnt <= 5'h00;
      en_q   <= 1'b0;
      en_ok  <= 1'b0;
      run_q  <= 1'b0;
    end
    else
    begin
      lo_cnt <= init_reset_n ? 5'h00 : lo_cnt + 5'h01;
      if (!init_reset_n)
      begin
        en_ok <= 1'b0;
        run_q <= 1'b0;
      end
      else if (wr && paddr == 12'h004)
      begin
        en_ok <= 1'b1;
        en_q  <= pwdata[7];
      end
      else if (wr && paddr == 12'h00C && pwdata[4])
      begin
        run_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_no_wait: assert property (pready) else $error("wait state seen");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h024 |-> pslverr)
    else $error("unmapped access not refused");
  a_init_width: assert property ($rose(init_reset_n) |-> lo_cnt == 5'h0B)
    else $error("init pulse width wrong");
  a_stop_choice: assert property (wr && paddr == 12'h000 && pwdata[7] && en_ok
    && init_reset_n && !in_stop && !in_shutdown |=> in_stop && in_shutdown == en_q)
    else $error("stop request took wrong state");
  a_float_in_stop: assert property ((pulls_disabled || pins_hiz) |-> in_stop || in_shutdown)
    else $error("pins floated outside stop");
  a_leave_init: assert property ($fell(in_shutdown) |-> !init_reset_n)
    else $error("shutdown left without init");
  a_ext_wake: assert property (in_shutdown && ext_wake |-> ##[1:3] !init_reset_n)
    else $error("external wake ignored");
  a_clear_pulse: assert property (wr && paddr == 12'h010 && !pwdata[3]
    |=> wdog_clear ##1 !wdog_clear) else $error("clear pulse wrong");
  a_rc_forced: assert property (run_q |-> clk_ctrl.rc_osc_on)
    else $error("rc off with watchdog in stop");
  a_sub_subst: assert property ((clk_ctrl.sub_osc_on && evt_in.sub_osc_fail)[*7]
    |-> clk_ctrl.sub_from_rc_div2) else $error("no rc substitute");
  a_wd_in_run: assert property ($rose(evt_in.wdog_timeout) && init_reset_n && !in_stop
    && !in_shutdown |-> ##[1:6] !init_reset_n) else $error("timeout in run ignored");
endmodule : sdc_top_properties

bind sdc_top sdc_top_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .evt_in, .ext_wake, .init_reset_n, .in_stop,
  .in_shutdown, .pulls_disabled, .pins_hiz, .wdog_clear, .clk_ctrl);

// *** test/sdc_top_tb.sv ***
/*
  sdc_top_tb.sv: self-checking bench for sdc_top over apb and event pins.
  Assumes sdc_pkg and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
module sdc_top_tb;
  logic              pclk, presetn, psel, penable, pwrite, ext_wake, wake_irq;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rdv, d;
  logic              pready, pslverr, erv, init_reset_n, in_stop, in_shutdown;
  logic              pulls_disabled, pins_hiz, sub_reg_low, wdog_clear;
  sdc_pkg::sdc_evt_t evt_in;
  sdc_pkg::sdc_clk_t clk_ctrl;
  int                n_errors, total_checks, i;
  localparam logic [31:0] RV [10] = '{0, 0, 0, 0, 0, 32'h1C, 0, 0, 32'h01, 0};

  sdc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .evt_in, .ext_wake, .wake_irq, .init_reset_n, .in_stop,
    .in_shutdown, .pulls_disabled, .pins_hiz, .sub_reg_low, .wdog_clear, .clk_ctrl);

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] msk(input logic [11:0] a);
    return (a == 12'h020) ? 32'hFF : 32'h3;
  endfunction : msk

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask : rd

  // events held 8 cycles: long enough for the synchroniser, short of a second init
  task pulse(input logic [3:0] v, input logic x, input logic e);
    int k;
    logic seen;
    seen = 1'b0;
    evt_in <= v;
    ext_wake <= x;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      seen = seen | !init_reset_n;
      if (k == 7)
      begin
        evt_in <= 4'h0;
        ext_wake <= 1'b0;
      end
    end
    for (k = 0; k < 40 && init_reset_n !== 1'b1; k++)
      @(posedge pclk);
    chk(init_reset_n, 1'b1);
    chk(seen, e);
  endtask : pulse

  task results;
    if (n_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    results();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, ext_wake, wake_irq} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    evt_in = 4'h0;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'h5B70B64D));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 10; i++)
      rd(12'(i * 4), RV[i], 32'hFFFFFFFF);
    rd(12'h028, 32'h0, 32'hFFFFFFFF);
    chk(erv, 1'b1);
    for (i = 0; i < 12; i++)
    begin
      d = $urandom;
      wr(12'h018 + 12'(4 * (i % 3)), d);
      rd(12'h018 + 12'(4 * (i % 3)), d & msk(12'h018 + 12'(4 * (i % 3))), 32'hFFFFFFFF);
      if (i % 3 == 0)
        chk(clk_ctrl.rtc_clock_select, d[1:0]);
    end
    pulse(4'h8, 1'b0, 1'b1);
    wr(12'h000, 32'h98);
    chk(in_stop, 1'b1);
    chk(pulls_disabled, 1'b1);
    rd(12'h024, 32'h1, 32'h3);
    wake_irq <= 1'b1;
    for (i = 0; i < 10 && in_stop !== 1'b0; i++)
      @(posedge pclk);
    wake_irq <= 1'b0;
    chk(in_stop, 1'b0);
    wr(12'h000, 32'h80);
    pulse(4'h8, 1'b0, 1'b1);
    chk(in_stop, 1'b0);
    rd(12'h008, 32'h0, 32'h8);
    wr(12'h00C, 32'h10);
    wr(12'h00C, 32'h00);
    rd(12'h00C, 32'h10, 32'h10);
    rd(12'h008, 32'h4, 32'h4);
    wr(12'h014, 32'h0C);
    wr(12'h020, 32'h00);
    wr(12'h004, 32'h80);
    wr(12'h010, 32'h00);
    wr(12'h01C, 32'h03);
    chk(clk_ctrl.cpu_on_rc, 1'b0);
    wr(12'h000, 32'hDC);
    rd(12'h000, 32'h5C, 32'hFF);
    rd(12'h000, 32'h5C, 32'hFF);
    chk(in_shutdown, 1'b1);
    chk(clk_ctrl.main_osc_on, 1'b0);
    chk(clk_ctrl.sub_osc_on, 1'b1);
    chk(pins_hiz, 1'b1);
    chk(sub_reg_low, 1'b1);
    chk(clk_ctrl.rc_osc_on, 1'b1);
    pulse(4'h8, 1'b0, 1'b1);
    rd(12'h008, 32'h8, 32'h8);
    rd(12'h000, 32'h0C, 32'hFF);
    rd(12'h004, 32'h0, 32'h80);
    chk(clk_ctrl.cpu_on_rc, 1'b0);
    wr(12'h008, 32'h1);
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h80);
    pulse(4'h1, 1'b0, 1'b1);
    rd(12'h008, 32'h2, 32'h2);
    wr(12'h008, 32'h0);
    rd(12'h008, 32'h4, 32'hE);
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h80);
    pulse(4'h0, 1'b1, 1'b1);
    wr(12'h014, 32'h1C);
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h80);
    pulse(4'h4, 1'b0, 1'b1);
    chk(clk_ctrl.cpu_on_rc, 1'b1);
    pulse(4'h2, 1'b0, 1'b0);
    chk(clk_ctrl.sub_from_rc_div2, 1'b1);
    rd(12'h024, 32'h8, 32'h8);
    // mid-run reset: run-in-stop must drop, supervisor back on
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h00C, 32'h0, 32'h10);
    rd(12'h014, 32'h1C, 32'hFF);
    wr(12'h004, 32'h80);
    wr(12'h000, 32'h80);
    pulse(4'h4, 1'b0, 1'b0);
    chk(in_shutdown, 1'b1);
    pulse(4'h0, 1'b1, 1'b1);
    results();
  end
endmodule : sdc_top_tb
